// ==== hmwb_pkg.sv ====
// shared constants and types of the host memory window bridge
package hmwb_pkg;

	// ********************************************************
	// host port byte offsets
	// ********************************************************
	localparam logic [3:0] OFF_ADDR_LSB = 4'h2;
	localparam logic [3:0] OFF_ADDR_MSB = 4'h3;
	localparam logic [3:0] OFF_DATA0 = 4'h4;
	localparam logic [3:0] OFF_DATA3 = 4'h7;
	localparam logic [3:0] OFF_APP_ID = 4'hC;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int LSB_ACC_HI = 1;
	localparam int LSB_ACC_LO = 0;
	localparam int LSB_OFS_HI = 7;
	localparam int LSB_OFS_LO = 2;
	localparam int MSB_OFS_HI = 6;
	localparam int MSB_REGION_BIT = 7;

	// ********************************************************
	// widths, reset values and steps
	// ********************************************************
	localparam int OFS_W = 15;
	localparam int DW_W = 13;
	localparam int LIM_W = 16;
	localparam logic [7:0] ADDR_LSB_RST = 8'h00;
	localparam logic [7:0] ADDR_MSB_RST = 8'h00;
	localparam logic [7:0] APP_ID_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	localparam logic [12:0] DW_STEP = 13'h0001;

	typedef enum logic [1:0]
	{
		ACC_8 = 2'b00,
		ACC_16 = 2'b01,
		ACC_32 = 2'b10,
		ACC_AUTO = 2'b11
	} hmwb_acc_e;

	typedef enum logic [0:0] {ST_IDLE, ST_WAIT} hmwb_state_e;

endpackage

// ==== hmwb_mem_if.sv ====
// request and answer signals between bridge core and memory port
`timescale 1ns/1ns
interface hmwb_mem_if;
	logic start;
	logic we;
	logic [31:0] addr;
	logic [3:0] be;
	logic [31:0] wdata;
	logic done;
	logic [31:0] rdata;

	modport ctrl
	(
		output start,
		output we,
		output addr,
		output be,
		output wdata,
		input done,
		input rdata
	);

	modport port
	(
		input start,
		input we,
		input addr,
		input be,
		input wdata,
		output done,
		output rdata
	);
endinterface

// ==== hmwb_mem_port.sv ====
// internal memory bus master: holds a request until acknowledged
`timescale 1ns/1ns
module hmwb_mem_port
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	hmwb_mem_if.port req,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [3:0] mem_be,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	logic req_reg, req_next;
	logic we_reg, we_next;
	logic [31:0] addr_reg, addr_next;
	logic [3:0] be_reg, be_next;
	logic [31:0] wdata_reg, wdata_next;
	logic done_reg, done_next;
	logic [31:0] rdata_reg, rdata_next;

	always_comb
	begin
		req_next = req_reg;
		we_next = we_reg;
		addr_next = addr_reg;
		be_next = be_reg;
		wdata_next = wdata_reg;
		done_next = 1'b0;
		rdata_next = rdata_reg;
		if (req_reg)
		begin
			// an ack outside a request is ignored
			if (mem_ack)
			begin
				req_next = 1'b0;
				done_next = 1'b1;
				if (!we_reg)
				begin
					rdata_next = mem_rdata;
				end
			end
		end
		else if (req.start)
		begin
			req_next = 1'b1;
			we_next = req.we;
			addr_next = req.addr;
			be_next = req.be;
			wdata_next = req.wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			req_reg <= 1'b0;
			we_reg <= 1'b0;
			addr_reg <= 32'h0000_0000;
			be_reg <= 4'h0;
			wdata_reg <= 32'h0000_0000;
			done_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else if (ce)
		begin
			req_reg <= req_next;
			we_reg <= we_next;
			addr_reg <= addr_next;
			be_reg <= be_next;
			wdata_reg <= wdata_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
		end
	end

	assign mem_req = req_reg;
	assign mem_we = we_reg;
	assign mem_addr = addr_reg;
	assign mem_be = be_reg;
	assign mem_wdata = wdata_reg;
	assign req.done = done_reg;
	assign req.rdata = rdata_reg;
endmodule

// ==== hmwb_bridge.sv ====
// host byte port into two windows of the internal memory space
`timescale 1ns/1ns

// How it works
// - host reaches two windows of the 32-bit internal address space.
// - window base and limits come from controller-only ports, never host.
// - read and write limits are independent; windows may overlap.
// - zero read limit with nonzero write limit makes a write-only window.
// - each window offset spans up to 32k bytes.
// - four data bytes form one dword-aligned 32-bit data register.
// - two address bytes form the 15-bit window_offset.
// - write outside write area updates data register only, not memory.
// - read outside read area does no fetch and keeps data register.
// - auto mode: out-of-bounds byte 3 read advances, write does not.
// - auto mode acts as 32-bit mode and byte 3 access advances a dword.
// - 32-bit mode: byte 0 read fetches whole dword; others do not.
// - 32-bit mode: byte 3 write stores whole dword; others register only.
// - 16-bit mode: byte 0 and byte 2 reads fetch halfwords.
// - 16-bit mode: byte 1 and byte 3 writes store halfwords.
// - 8-bit mode: every byte read fetches and every byte write stores.
// - access size field in address low byte chooses the access kind.
// - the two lowest window_offset bits always read as zero.
// - memory address is selected window base plus window_offset.
module hmwb_bridge
(
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	input wire logic [3:0] HOST_ADDR,
	input wire logic [7:0] HOST_WDATA,
	output logic [7:0] HOST_RDATA,
	output logic HOST_RVALID,
	output logic HOST_BUSY,
	input wire logic [31:0] WIN0_BASE,
	input wire logic [15:0] WIN0_RD_LIMIT,
	input wire logic [15:0] WIN0_WR_LIMIT,
	input wire logic [31:0] WIN1_BASE,
	input wire logic [15:0] WIN1_RD_LIMIT,
	input wire logic [15:0] WIN1_WR_LIMIT,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [31:0] MEM_ADDR,
	output logic [3:0] MEM_BE,
	output logic [31:0] MEM_WDATA,
	input wire logic MEM_ACK,
	input wire logic [31:0] MEM_RDATA
);

	// ********************************************************
	// lane selection per access size
	// ********************************************************

	// byte enables of the memory access that a data byte access causes;
	// zero means the access only touches the data register
	function automatic logic [3:0] hmwb_lanes
	(
		input logic [1:0] acc,
		input logic [1:0] lane,
		input logic wr
	);
		logic [3:0] m;
		m = 4'h0;
		case (acc)
			hmwb_pkg::ACC_8:
			begin
				m = 4'h1 << lane;
			end
			hmwb_pkg::ACC_16:
			begin
				if (!wr && lane == 2'd0)
				begin
					m = 4'h3;
				end
				else if (!wr && lane == 2'd2)
				begin
					m = 4'hC;
				end
				else if (wr && lane == 2'd1)
				begin
					m = 4'h3;
				end
				else if (wr && lane == 2'd3)
				begin
					m = 4'hC;
				end
			end
			default:
			begin
				// auto mode shares the 32-bit lane pattern
				if (!wr && lane == 2'd0)
				begin
					m = 4'hF;
				end
				else if (wr && lane == 2'd3)
				begin
					m = 4'hF;
				end
			end
		endcase
		return m;
	endfunction

	// ********************************************************
	// state
	// ********************************************************
	hmwb_pkg::hmwb_state_e state_reg, state_next;
	logic [7:0] addr_lsb_reg, addr_lsb_next;
	logic [7:0] addr_msb_reg, addr_msb_next;
	logic [7:0] app_id_reg, app_id_next;
	logic [7:0] data_reg [4];
	logic [7:0] data_next [4];
	logic [1:0] pend_lane_reg, pend_lane_next;
	logic pend_rd_reg, pend_rd_next;
	logic pend_inc_reg, pend_inc_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic busy_reg, busy_next;
	logic start_reg, start_next;
	logic we_reg, we_next;
	logic [31:0] maddr_reg, maddr_next;
	logic [3:0] be_reg, be_next;
	logic [31:0] wdata_reg, wdata_next;

	hmwb_mem_if mif();

	// ********************************************************
	// window decode
	// ********************************************************
	logic [hmwb_pkg::OFS_W-1:0] offset;
	logic [hmwb_pkg::DW_W-1:0] dw_index;
	logic [hmwb_pkg::DW_W-1:0] dw_inc;
	logic region;
	logic [31:0] base;
	logic [hmwb_pkg::LIM_W-1:0] rd_limit;
	logic [hmwb_pkg::LIM_W-1:0] wr_limit;
	logic rd_ok;
	logic wr_ok;
	logic [31:0] win_addr;
	logic [1:0] acc;
	logic [1:0] lane;
	logic is_data;
	logic is_auto;
	logic [3:0] rd_lanes;
	logic [3:0] wr_lanes;
	logic [7:0] merged [4];
	logic [31:0] wr_word;

	assign dw_index = {addr_msb_reg[hmwb_pkg::MSB_OFS_HI:0],
		addr_lsb_reg[hmwb_pkg::LSB_OFS_HI:hmwb_pkg::LSB_OFS_LO]};
	assign offset = {dw_index, 2'b00};
	assign dw_inc = dw_index + hmwb_pkg::DW_STEP;
	assign region = addr_msb_reg[hmwb_pkg::MSB_REGION_BIT];
	// base and limits arrive on controller-side ports; the host port
	// has no path to them at all
	assign base = region ? WIN1_BASE : WIN0_BASE;
	assign rd_limit = region ? WIN1_RD_LIMIT : WIN0_RD_LIMIT;
	assign wr_limit = region ? WIN1_WR_LIMIT : WIN0_WR_LIMIT;
	// separate compares: a zero read limit blocks every memory fetch while
	// writes still pass, giving a write-only window
	assign rd_ok = {1'b0, offset} < rd_limit;
	assign wr_ok = {1'b0, offset} < wr_limit;
	assign win_addr = base + {17'h0_0000, offset};
	assign acc = addr_lsb_reg[hmwb_pkg::LSB_ACC_HI:hmwb_pkg::LSB_ACC_LO];
	assign lane = HOST_ADDR[1:0];
	assign is_data = (HOST_ADDR >= hmwb_pkg::OFF_DATA0) &&
		(HOST_ADDR <= hmwb_pkg::OFF_DATA3);
	assign is_auto = (acc == hmwb_pkg::ACC_AUTO);
	assign rd_lanes = hmwb_lanes(acc, lane, 1'b0);
	assign wr_lanes = hmwb_lanes(acc, lane, 1'b1);

	// fetched lanes replace register bytes, the rest are kept
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_merge
			assign merged[g] = be_reg[g] ? mif.rdata[8*g +: 8] : data_reg[g];
			assign wr_word[8*g +: 8] = (lane == g) ? HOST_WDATA : data_reg[g];
		end
	endgenerate

	// ********************************************************
	// next state
	// ********************************************************
	always_comb
	begin
		state_next = state_reg;
		addr_lsb_next = addr_lsb_reg;
		addr_msb_next = addr_msb_reg;
		app_id_next = app_id_reg;
		for (int i = 0; i < 4; i++)
		begin
			data_next[i] = data_reg[i];
		end
		pend_lane_next = pend_lane_reg;
		pend_rd_next = pend_rd_reg;
		pend_inc_next = pend_inc_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		start_next = 1'b0;
		we_next = we_reg;
		maddr_next = maddr_reg;
		be_next = be_reg;
		wdata_next = wdata_reg;
		case (state_reg)
			hmwb_pkg::ST_IDLE:
			begin
				if (HOST_WR)
				begin
					if (HOST_ADDR == hmwb_pkg::OFF_ADDR_LSB)
					begin
						addr_lsb_next = HOST_WDATA;
					end
					else if (HOST_ADDR == hmwb_pkg::OFF_ADDR_MSB)
					begin
						addr_msb_next = HOST_WDATA;
					end
					else if (HOST_ADDR == hmwb_pkg::OFF_APP_ID)
					begin
						// plain storage; ownership is a software convention
						app_id_next = HOST_WDATA;
					end
					else if (is_data)
					begin
						data_next[lane] = HOST_WDATA;
						if (wr_lanes != 4'h0 && wr_ok)
						begin
							start_next = 1'b1;
							we_next = 1'b1;
							maddr_next = win_addr;
							be_next = wr_lanes;
							wdata_next = wr_word;
							pend_rd_next = 1'b0;
							// advance only for an accepted store
							pend_inc_next = is_auto && lane == 2'd3;
							state_next = hmwb_pkg::ST_WAIT;
						end
					end
				end
				else if (HOST_RD)
				begin
					rvalid_next = 1'b1;
					if (HOST_ADDR == hmwb_pkg::OFF_ADDR_LSB)
					begin
						rdata_next = addr_lsb_reg;
					end
					else if (HOST_ADDR == hmwb_pkg::OFF_ADDR_MSB)
					begin
						rdata_next = addr_msb_reg;
					end
					else if (HOST_ADDR == hmwb_pkg::OFF_APP_ID)
					begin
						rdata_next = app_id_reg;
					end
					else if (is_data)
					begin
						if (rd_lanes != 4'h0 && rd_ok)
						begin
							rvalid_next = 1'b0;
							start_next = 1'b1;
							we_next = 1'b0;
							maddr_next = win_addr;
							be_next = rd_lanes;
							pend_rd_next = 1'b1;
							pend_lane_next = lane;
							pend_inc_next = is_auto && lane == 2'd3;
							state_next = hmwb_pkg::ST_WAIT;
						end
						else
						begin
							// no fetch: return what the register holds
							rdata_next = data_reg[lane];
							if (is_auto && lane == 2'd3)
							begin
								addr_lsb_next[hmwb_pkg::LSB_OFS_HI:
									hmwb_pkg::LSB_OFS_LO] = dw_inc[5:0];
								addr_msb_next[hmwb_pkg::MSB_OFS_HI:0] =
									dw_inc[12:6];
							end
						end
					end
					else
					begin
						rdata_next = hmwb_pkg::UNMAPPED_RD;
					end
				end
			end
			hmwb_pkg::ST_WAIT:
			begin
				// host requests in this state are not taken; busy shows it
				if (mif.done)
				begin
					if (pend_rd_reg)
					begin
						for (int i = 0; i < 4; i++)
						begin
							data_next[i] = merged[i];
						end
						rdata_next = merged[pend_lane_reg];
						rvalid_next = 1'b1;
					end
					if (pend_inc_reg)
					begin
						addr_lsb_next[hmwb_pkg::LSB_OFS_HI:
							hmwb_pkg::LSB_OFS_LO] = dw_inc[5:0];
						addr_msb_next[hmwb_pkg::MSB_OFS_HI:0] =
							dw_inc[12:6];
					end
					pend_inc_next = 1'b0;
					state_next = hmwb_pkg::ST_IDLE;
				end
			end
			default:
			begin
				state_next = hmwb_pkg::ST_IDLE;
			end
		endcase
		busy_next = (state_next != hmwb_pkg::ST_IDLE);
	end

	// ********************************************************
	// registers
	// ********************************************************
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			state_reg <= hmwb_pkg::ST_IDLE;
			addr_lsb_reg <= hmwb_pkg::ADDR_LSB_RST;
			addr_msb_reg <= hmwb_pkg::ADDR_MSB_RST;
			app_id_reg <= hmwb_pkg::APP_ID_RST;
			for (int i = 0; i < 4; i++)
			begin
				data_reg[i] <= hmwb_pkg::DATA_RST;
			end
			pend_lane_reg <= 2'b00;
			pend_rd_reg <= 1'b0;
			pend_inc_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
			busy_reg <= 1'b0;
			start_reg <= 1'b0;
			we_reg <= 1'b0;
			maddr_reg <= 32'h0000_0000;
			be_reg <= 4'h0;
			wdata_reg <= 32'h0000_0000;
		end
		else if (CE)
		begin
			state_reg <= state_next;
			addr_lsb_reg <= addr_lsb_next;
			addr_msb_reg <= addr_msb_next;
			app_id_reg <= app_id_next;
			for (int i = 0; i < 4; i++)
			begin
				data_reg[i] <= data_next[i];
			end
			pend_lane_reg <= pend_lane_next;
			pend_rd_reg <= pend_rd_next;
			pend_inc_reg <= pend_inc_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			busy_reg <= busy_next;
			start_reg <= start_next;
			we_reg <= we_next;
			maddr_reg <= maddr_next;
			be_reg <= be_next;
			wdata_reg <= wdata_next;
		end
	end

	assign mif.start = start_reg;
	assign mif.we = we_reg;
	assign mif.addr = maddr_reg;
	assign mif.be = be_reg;
	assign mif.wdata = wdata_reg;

	// ********************************************************
	// memory bus master
	// ********************************************************
	hmwb_mem_port u_mem_port
	(
		.clk(MCLK),
		.rst_n(RST_B),
		.ce(CE),
		.req(mif.port),
		.mem_req(MEM_REQ),
		.mem_we(MEM_WE),
		.mem_addr(MEM_ADDR),
		.mem_be(MEM_BE),
		.mem_wdata(MEM_WDATA),
		.mem_ack(MEM_ACK),
		.mem_rdata(MEM_RDATA)
	);

	assign HOST_RDATA = rdata_reg;
	assign HOST_RVALID = rvalid_reg;
	assign HOST_BUSY = busy_reg;
endmodule

// ==== hmwb_mem_model.sv ====
// internal memory model on the far side of the bridge
`timescale 1ns/1ns
module hmwb_mem_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [3:0] mem_be,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [0:255];
	int n_req = 0;
	int wait_cnt = 0;
	int lat = 0;
	logic served = 1'b0;
	wire [7:0] idx = mem_addr[9:2];

	initial
	begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0000_0000;
	end

	// latency swaps between prompt and slow on every request
	always @(posedge clk)
	begin
		mem_ack <= 1'b0;
		// read data is not held once the answer is gone
		mem_rdata <= ~mem_rdata;
		if (!rst_n || !mem_req)
		begin
			wait_cnt <= 0;
			served <= 1'b0;
		end
		else if (!served && wait_cnt >= lat)
		begin
			mem_ack <= 1'b1;
			served <= 1'b1;
			n_req <= n_req + 1;
			lat <= 3 - lat;
			if (!mem_we)
				mem_rdata <= mem[idx];
			for (int i = 0; i < 4; i++)
				if (mem_we && mem_be[i])
					mem[idx][8*i +: 8] <= mem_wdata[8*i +: 8];
		end
		else if (!served)
			wait_cnt <= wait_cnt + 1;
	end
endmodule

// ==== hmwb_bridge_chk.sv ====
// concurrent checks on the ports of the host memory window bridge
`timescale 1ns/1ns
module hmwb_bridge_chk
(
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	input wire logic [3:0] HOST_ADDR,
	input wire logic HOST_RVALID,
	input wire logic HOST_BUSY,
	input wire logic MEM_REQ,
	input wire logic MEM_WE,
	input wire logic [31:0] MEM_ADDR,
	input wire logic [3:0] MEM_BE,
	input wire logic MEM_ACK
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	wire rd_take = HOST_RD && !HOST_WR && !HOST_BUSY && CE;
	wire wr_take = HOST_WR && !HOST_BUSY && CE;
	wire acked = MEM_REQ && MEM_ACK && CE;

	a_req_hold: assert property (MEM_REQ && !MEM_ACK && CE |=>
		MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE))
		else $error("memory request dropped or changed before ack");
	a_addr_align: assert property (MEM_REQ |-> MEM_ADDR[1:0] == 2'b00)
		else $error("memory address not dword aligned");
	a_req_busy: assert property (MEM_REQ |-> HOST_BUSY)
		else $error("memory request while host port not busy");
	a_ack_release: assert property (acked |=> !MEM_REQ)
		else $error("memory request still high after ack");
	a_fetch_answer: assert property (acked && !MEM_WE |-> ##2 HOST_RVALID)
		else $error("fetch not answered two cycles after ack");
	a_write_quiet: assert property (wr_take |=> !HOST_RVALID)
		else $error("host write produced a read answer");
	a_reg_answer: assert property (rd_take && (HOST_ADDR ==
		hmwb_pkg::OFF_ADDR_LSB || HOST_ADDR == hmwb_pkg::OFF_APP_ID)
		|=> HOST_RVALID) else $error("register read not answered");
	a_data_start: assert property (rd_take && HOST_ADDR ==
		hmwb_pkg::OFF_DATA0 |=> HOST_BUSY || HOST_RVALID)
		else $error("data byte 0 read neither fetched nor answered");
	a_write_lanes: assert property (MEM_REQ && MEM_WE |-> MEM_BE inside
		{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
		else $error("memory write with illegal byte lanes");
endmodule

bind hmwb_bridge hmwb_bridge_chk chk_u
(
	.MCLK(MCLK), .RST_B(RST_B), .CE(CE), .HOST_WR(HOST_WR),
	.HOST_RD(HOST_RD), .HOST_ADDR(HOST_ADDR), .HOST_RVALID(HOST_RVALID),
	.HOST_BUSY(HOST_BUSY), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
	.MEM_ADDR(MEM_ADDR), .MEM_BE(MEM_BE), .MEM_ACK(MEM_ACK)
);

// ==== hmwb_bridge_tb.sv ====
// self-checking bench of the host memory window bridge
`timescale 1ns/1ns
module hmwb_bridge_tb;
	localparam logic [3:0] AL = hmwb_pkg::OFF_ADDR_LSB;
	localparam logic [3:0] AH = hmwb_pkg::OFF_ADDR_MSB;
	localparam logic [3:0] D0 = hmwb_pkg::OFF_DATA0;
	localparam logic [3:0] D3 = hmwb_pkg::OFF_DATA3;
	localparam logic [3:0] AI = hmwb_pkg::OFF_APP_ID;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [31:0] w0b = 32'h0000_0000;
	logic [31:0] w1b = 32'h0000_0000;
	logic [15:0] w0r = 16'h0000;
	logic [15:0] w0w = 16'h0000;
	logic [15:0] w1r = 16'h0000;
	logic [15:0] w1w = 16'h0000;
	logic [7:0] rdata;
	logic rvalid, busy, mreq, mwe, mack;
	logic [3:0] mbe;
	logic [31:0] maddr, mwdata, mrdata;
	int bad_count = 0;
	int comparisons = 0;

	hmwb_bridge dut_u
	(
		.MCLK(mclk), .RST_B(rst_b), .CE(ce), .HOST_WR(wr), .HOST_RD(rd),
		.HOST_ADDR(addr), .HOST_WDATA(wdata), .HOST_RDATA(rdata),
		.HOST_RVALID(rvalid), .HOST_BUSY(busy), .WIN0_BASE(w0b),
		.WIN0_RD_LIMIT(w0r), .WIN0_WR_LIMIT(w0w), .WIN1_BASE(w1b),
		.WIN1_RD_LIMIT(w1r), .WIN1_WR_LIMIT(w1w), .MEM_REQ(mreq),
		.MEM_WE(mwe), .MEM_ADDR(maddr), .MEM_BE(mbe), .MEM_WDATA(mwdata),
		.MEM_ACK(mack), .MEM_RDATA(mrdata)
	);
	hmwb_mem_model mem_u
	(
		.clk(mclk), .rst_n(rst_b), .mem_req(mreq), .mem_we(mwe),
		.mem_addr(maddr), .mem_be(mbe), .mem_wdata(mwdata),
		.mem_ack(mack), .mem_rdata(mrdata)
	);

	always #20 mclk = ~mclk;

	// ****************************************
	// host port tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// values read right after an edge are those the edge sampled
	task automatic hw(input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (busy !== 1'b0 && n < 60);
		chk("busy", 1'b0, busy);
	endtask

	task automatic hr(input logic [3:0] a, output logic [7:0] d);
		int n;
		n = 0;
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (rvalid !== 1'b1 && n < 60);
		chk("rvalid", 1'b1, rvalid);
		d = rdata;
	endtask

	task automatic setad(input logic w, input logic [14:0] o,
		input logic [1:0] acc);
		hw(AL, {o[7:2], acc});
		hw(AH, {w, o[14:8]});
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		logic [7:0] d;
		hr(AL, d);
		chk("addr_lsb", hmwb_pkg::ADDR_LSB_RST, d);
		hr(AI, d);
		chk("app_id", hmwb_pkg::APP_ID_RST, d);
		hw(AI, 8'hA5);
		hr(AI, d);
		chk("app_id", 8'hA5, d);
		hw(AH, 8'hFF);
		hr(AH, d);
		chk("addr_msb", 8'hFF, d);
		hr(4'h0, d);
		chk("unmapped", hmwb_pkg::UNMAPPED_RD, d);
		$display("t_regs end");
	endtask

	task automatic t_32();
		logic [7:0] d;
		int k;
		w0b <= 32'h0000_0100;
		w0r <= 16'h0040;
		w0w <= 16'h0040;
		mem_u.mem[8'h42] = 32'h4433_2211;
		setad(1'b0, 15'h0008, hmwb_pkg::ACC_32);
		k = mem_u.n_req;
		for (int i = 0; i < 4; i++)
		begin
			hr(D0 + 4'(i), d);
			chk("d32", 32'h4433_2211 >> (8 * i) & 32'hFF, d);
		end
		chk("fetches", 32'(k + 1), 32'(mem_u.n_req));
		for (int i = 0; i < 4; i++)
			hw(D0 + 4'(i), 8'hA0 + 8'(i));
		chk("store32", 32'hA3A2_A1A0, mem_u.mem[8'h42]);
		chk("stores", 32'(k + 2), 32'(mem_u.n_req));
		$display("t_32 end");
	endtask

	task automatic t_small();
		logic [7:0] d;
		mem_u.mem[8'h42] = 32'h8877_6655;
		setad(1'b0, 15'h0008, hmwb_pkg::ACC_16);
		hr(D0 + 4'h2, d);
		chk("d16", 8'h77, d);
		mem_u.mem[8'h42] = 32'h9977_6655;
		hr(D3, d);
		chk("d16_held", 8'h88, d);
		hw(D0, 8'h01);
		hw(D0 + 4'h1, 8'h02);
		chk("store16", 32'h9977_0201, mem_u.mem[8'h42]);
		setad(1'b0, 15'h0008, hmwb_pkg::ACC_8);
		hr(D3, d);
		chk("d8", 8'h99, d);
		hw(D0 + 4'h2, 8'h5E);
		chk("store8", 32'h995E_0201, mem_u.mem[8'h42]);
		$display("t_small end");
	endtask

	task automatic t_lim();
		logic [7:0] d;
		int k;
		w1b <= 32'h0000_0200;
		w1r <= 16'h0000;
		w1w <= 16'h0010;
		mem_u.mem[8'h84] = 32'h0000_0000;
		setad(1'b1, 15'h0000, hmwb_pkg::ACC_32);
		for (int i = 0; i < 4; i++)
			hw(D0 + 4'(i), 8'hB0 + 8'(i));
		chk("wr_only", 32'hB3B2_B1B0, mem_u.mem[8'h80]);
		k = mem_u.n_req;
		hr(D0, d);
		chk("no_fetch", 8'hB0, d);
		setad(1'b1, 15'h0010, hmwb_pkg::ACC_32);
		hw(D3, 8'hC3);
		chk("no_store", 32'h0000_0000, mem_u.mem[8'h84]);
		hr(D3, d);
		chk("reg_upd", 8'hC3, d);
		chk("no_access", 32'(k), 32'(mem_u.n_req));
		$display("t_lim end");
	endtask

	task automatic t_auto();
		logic [7:0] d;
		w0r <= 16'h0020;
		w0w <= 16'h0010;
		setad(1'b0, 15'h000C, hmwb_pkg::ACC_AUTO);
		hr(D3, d);
		hr(AL, d);
		chk("auto_rd", 8'h13, d);
		hw(D3, 8'h11);
		hr(AL, d);
		chk("oob_wr", 8'h13, d);
		setad(1'b0, 15'h0020, hmwb_pkg::ACC_AUTO);
		hr(D3, d);
		hr(AL, d);
		chk("oob_rd", 8'h27, d);
		// in-bounds byte 3 store advances, byte 0 fetch does not
		mem_u.mem[8'h43] = 32'h1234_5678;
		setad(1'b0, 15'h0008, hmwb_pkg::ACC_AUTO);
		hw(D3, 8'h77);
		chk("auto_st", 32'h77B2_B1B0, mem_u.mem[8'h42]);
		hr(AL, d);
		chk("auto_wr", 8'h0F, d);
		hr(D0, d);
		chk("auto_d0", 8'h78, d);
		hr(AL, d);
		chk("auto_hold", 8'h0F, d);
		$display("t_auto end");
	endtask

	task automatic t_freeze();
		logic [7:0] d;
		// a write while the clock enable is low must be lost
		ce <= 1'b0;
		hw(AI, 8'h5A);
		ce <= 1'b1;
		hr(AI, d);
		chk("frozen_id", 8'hA5, d);
		rst_b <= 1'b0;
		@(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		hr(AI, d);
		chk("rst_id", hmwb_pkg::APP_ID_RST, d);
		hr(AL, d);
		chk("rst_lsb", hmwb_pkg::ADDR_LSB_RST, d);
		$display("t_freeze end");
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_32();
		t_small();
		t_lim();
		t_auto();
		t_freeze();
		close_out();
	end

	// the whole run needs a few hundred cycles
	initial
	begin
		#(40 * 20000);
		bad_count++;
		close_out();
	end
endmodule
